// ==== logic/cvc_top.sv ====
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "cvc_map.svh"
// comparator and voltage reference control
module cvc_top
  import cvc_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  // register port
  input  wire logic  [7:0] reg_addr_i,
  input  wire logic  [7:0] reg_wdata_i,
  input  wire logic  reg_wr_i,
  input  wire logic  reg_rd_i,
  output cvc_byte_t  reg_rdata_o,
  // analog comparator outputs and core state
  input  wire logic  cmp_first_raw_i,
  input  wire logic  cmp_second_raw_i,
  input  wire logic  sleep_i,
  // comparator control
  output logic [1:0] cmp_power_o,
  output cvc_mode_t  comparator_mode_field_o,
  output logic       input_switch_bit_o,
  output logic       cmp_use_ref_o,
  output logic       pins_all_analog_o,
  output logic       first_compare_result_o,
  output logic       second_compare_result_o,
  output logic       compare_change_flag_o,
  output logic       compare_change_enable_o,
  output logic       cmp_irq_req_o,
  output logic       wake_o,
  output logic [4:0] porta_direction_o,
  // port A lines 3 and 4 output path
  output logic       porta_line_three_o,
  output logic       porta_line_three_oe_b_o,
  output logic       porta_line_four_o,
  output logic       porta_line_four_oe_b_o,
  // voltage reference
  output logic       ref_power_on_o,
  output logic       ref_range_select_o,
  output cvc_tap_t   ref_tap_select_o,
  output cvc_level_t ref_level_o,
  output logic       ref_line_two_connect_o
);

  // ==========================================
  // decode helpers

  // true when the address equals the given byte offset; the caller adds any strobe
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // true when the mode field holds a given mode
  function automatic logic mode_is(input cvc_mode_t m, input cvc_mode_t want);
    mode_is = (m == want);
  endfunction : mode_is

  // ==========================================
  // storage

  cvc_mode_t  mode_q;
  logic       switch_q;
  logic [4:0] dir_q;
  logic       enable_q;
  logic       flag_q;
  logic       flag_d;
  cvc_byte_t  ref_q;
  logic       last_first_q;
  logic       last_second_q;
  logic [1:0] power_q;
  logic [1:0] power_d;
  logic       wake_q;
  cvc_byte_t  rdata_q;
  cvc_byte_t  rdata_d;

  logic       first_sync;
  logic       second_sync;
  logic       mismatch;
  logic       cmp_touch;
  logic       wr_cmp;
  logic       wr_dir;
  logic       wr_ena;
  logic       wr_flag;
  logic       wr_ref;
  logic       drive_three;
  logic       drive_four;

  cvc_ref_if  ref_if ();

  // ==========================================
  // synchronisers for the comparator outputs

  cvc_sync u_sync_first (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (cmp_first_raw_i),
    .q_o     (first_sync)
  );

  cvc_sync u_sync_second (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (cmp_second_raw_i),
    .q_o     (second_sync)
  );

  // ==========================================
  // write decode

  // one strobe, one register; other addresses are ignored
  assign wr_cmp  = reg_wr_i & hit(reg_addr_i, `CVC_OFS_CMP);
  assign wr_dir  = reg_wr_i & hit(reg_addr_i, `CVC_OFS_DIR);
  assign wr_ena  = reg_wr_i & hit(reg_addr_i, `CVC_OFS_ENA);
  assign wr_flag = reg_wr_i & hit(reg_addr_i, `CVC_OFS_FLAG);
  assign wr_ref  = reg_wr_i & hit(reg_addr_i, `CVC_OFS_REF);

  // any read or write of the comparator register ends a mismatch
  assign cmp_touch = (reg_wr_i | reg_rd_i) & hit(reg_addr_i, `CVC_OFS_CMP);

  // ==========================================
  // comparator control register

  // sleep_i is deliberately absent: waking never disturbs this state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q   <= CVC_MODE_RESET;
      switch_q <= 1'b0;
    end else if (wr_cmp) begin
      mode_q   <= cvc_mode_t'(reg_wdata_i[2:0]);
      switch_q <= reg_wdata_i[`CVC_BIT_SWITCH];
    end
  end
  // no sleep term above keeps wake-up harmless

  // ==========================================
  // comparator power

  // reset mode and off mode both leave the comparators unpowered
  always_comb begin
    if (mode_is(mode_q, CVC_MODE_OFF)) begin
      power_d = 2'b00;
    end else if (mode_is(mode_q, CVC_MODE_RESET)) begin
      power_d = 2'b00;
    end else begin
      power_d = 2'b11; // sleep has no say here
    end
  end

  // flop clears asynchronously so power is down the whole reset interval
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_q <= 2'b00;
    end else begin
      power_q <= power_d;
    end
  end

  // ==========================================
  // change detection against latched outputs

  // latched copy follows the live value only on a register touch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_first_q  <= 1'b0;
      last_second_q <= 1'b0;
    end else if (cmp_touch) begin
      last_first_q  <= first_sync;
      last_second_q <= second_sync;
    end
  end

  assign mismatch = (first_sync != last_first_q) | (second_sync != last_second_q);

  // ==========================================
  // change flag

  // mismatch sets and wins over a software clear in the same cycle;
  // software may also write a one to raise a test event
  always_comb begin
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = reg_wdata_i[`CVC_BIT_CHANGE];
    end
    if (mismatch) begin
      flag_d = 1'b1;
    end
  end

  // flag keeps working during sleep
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ==========================================
  // change enable

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable_q <= 1'b0;
    end else if (wr_ena) begin
      enable_q <= reg_wdata_i[`CVC_BIT_CHANGE];
    end
  end

  // ==========================================
  // wake request

  // held while asleep with an enabled pending change
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleep_i & flag_d & enable_q;
    end
  end

  // ==========================================
  // port A direction register

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_q <= `CVC_RST_DIR;
    end else if (wr_dir) begin
      dir_q <= reg_wdata_i[4:0];
    end
  end

  // ==========================================
  // reference control register

  // bit 4 is masked off so it can never hold a one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_q <= `CVC_RST_REF;
    end else if (wr_ref) begin
      ref_q <= reg_wdata_i & `CVC_MASK_REF;
    end
  end
  // nothing but a write changes it, so wake-up keeps it

  // ==========================================
  // reference outputs

  // mode field is not consulted anywhere here
  assign ref_power_on_o         = ref_q[`CVC_BIT_REF_POWER];
  assign ref_range_select_o     = ref_q[`CVC_BIT_REF_RANGE];
  assign ref_tap_select_o       = ref_q[3:0];
  assign ref_if.range_low       = ref_q[`CVC_BIT_REF_RANGE];
  assign ref_if.tap             = ref_q[3:0];
  assign ref_level_o            = ref_if.level;

  // switch closes only with the line set as input
  assign ref_line_two_connect_o = ref_q[`CVC_BIT_REF_PIN] & dir_q[`CVC_BIT_DIR_TWO];

  cvc_ladder u_ladder (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ref_if  (ref_if.ladder)
  );

  // ==========================================
  // pin output path for lines 3 and 4

  // raw outputs bypass the synchroniser on purpose: lowest latency to the pin
  assign drive_three = mode_is(mode_q, CVC_MODE_PINOUT) & ~dir_q[`CVC_BIT_DIR_THREE];
  assign drive_four  = mode_is(mode_q, CVC_MODE_PINOUT) & ~dir_q[`CVC_BIT_DIR_FOUR];

  assign porta_line_three_o      = cmp_first_raw_i & drive_three;
  assign porta_line_three_oe_b_o = ~drive_three;
  assign porta_line_four_o       = cmp_second_raw_i & drive_four;
  assign porta_line_four_oe_b_o  = ~drive_four;

  // ==========================================
  // read path

  // unmapped addresses and unimplemented bits read zero
  always_comb begin
    rdata_d = 8'h00;
    if (hit(reg_addr_i, `CVC_OFS_CMP)) begin
      rdata_d[`CVC_BIT_SECOND] = second_sync;
      rdata_d[`CVC_BIT_FIRST]  = first_sync;
      rdata_d[`CVC_BIT_SWITCH] = switch_q;
      rdata_d[2:0]             = mode_q;
    end else if (hit(reg_addr_i, `CVC_OFS_REF)) begin
      rdata_d = ref_q;
    end else if (hit(reg_addr_i, `CVC_OFS_DIR)) begin
      rdata_d[4:0] = dir_q;
    end else if (hit(reg_addr_i, `CVC_OFS_FLAG)) begin
      rdata_d[`CVC_BIT_CHANGE] = flag_q;
    end else if (hit(reg_addr_i, `CVC_OFS_ENA)) begin
      rdata_d[`CVC_BIT_CHANGE] = enable_q;
    end
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================
  // status outputs

  assign reg_rdata_o             = rdata_q;
  assign cmp_power_o             = power_q;
  assign comparator_mode_field_o = mode_q;
  assign input_switch_bit_o      = switch_q;
  assign cmp_use_ref_o           = mode_is(mode_q, CVC_MODE_REF);
  assign pins_all_analog_o       = mode_is(mode_q, CVC_MODE_RESET);
  assign first_compare_result_o  = first_sync;
  assign second_compare_result_o = second_sync;
  assign compare_change_flag_o   = flag_q;
  assign compare_change_enable_o = enable_q;
  assign cmp_irq_req_o           = flag_q & enable_q;
  assign wake_o                  = wake_q;
  assign porta_direction_o       = dir_q;

endmodule : cvc_top

// ==== logic/cvc_map.svh ====
`ifndef CVC_MAP_SVH
`define CVC_MAP_SVH
// Function
// - sleep keeps an active comparator running and its change interrupt working.
// - enabled comparator change during sleep wakes the device.
// - mode 111 switches both comparators off.
// - wake-up from sleep leaves the comparator control register unchanged.
// - reset clears comparator control register; mode 000, all pins analog.
// - both comparators powered down throughout reset.
// - reference bit 7 powers the ladder on or down.
// - reference bit 6 connects the reference onto port A line 2.
// - bit 5 set: tap/24 of supply; clear: supply/4 plus tap/32.
// - four-bit tap field bits 3..0 selects one of 16 levels.
// - reference bit 4 unimplemented, ignores writes, reads zero.
// - wake-up from sleep leaves the reference control register unchanged.
// - reset clears enable, pin drive, range and tap bits of reference.
// - reference reaches line 2 only with direction bit and pin drive set.
// - reference settings never depend on the comparator mode.
// - any comparator output change sets the change flag, flag register bit 6.
// - live/latched mismatch re-sets flag until comparator register read or write.
// - mode 110 routes raw comparator outputs to lines 3 and 4, direction-gated.
// - mode 010 applies the internal reference to both non-inverting inputs.

// ==========================================
// register offsets
`define CVC_OFS_FLAG   8'h0c
`define CVC_OFS_CMP    8'h1f
`define CVC_OFS_DIR    8'h85
`define CVC_OFS_ENA    8'h8c
`define CVC_OFS_REF    8'h9f

// ==========================================
// field positions
`define CVC_BIT_CHANGE     6
`define CVC_BIT_SECOND     7
`define CVC_BIT_FIRST      6
`define CVC_BIT_SWITCH     3
`define CVC_BIT_REF_POWER  7
`define CVC_BIT_REF_PIN    6
`define CVC_BIT_REF_RANGE  5
`define CVC_BIT_DIR_TWO    2
`define CVC_BIT_DIR_THREE  3
`define CVC_BIT_DIR_FOUR   4

// ==========================================
// reset values and write masks
`define CVC_RST_CMP    4'h0
`define CVC_RST_DIR    5'h1f
`define CVC_RST_REF    8'h00
`define CVC_MASK_REF   8'hef

// ==========================================
// ladder scaling, in 96ths of supply
`define CVC_LOW_STEP   7'h04
`define CVC_HIGH_BASE  7'h18
`define CVC_HIGH_STEP  7'h03
`endif

// ==== logic/cvc_pkg.sv ====
package cvc_pkg;
  // comparator modes that the block acts on
  typedef enum logic [2:0] {
    CVC_MODE_RESET  = 3'b000,
    CVC_MODE_REF    = 3'b010,
    CVC_MODE_PINOUT = 3'b110,
    CVC_MODE_OFF    = 3'b111
  } cvc_mode_t;

  typedef logic [7:0] cvc_byte_t;
  typedef logic [3:0] cvc_tap_t;
  typedef logic [6:0] cvc_level_t;
endpackage : cvc_pkg

// ==== logic/cvc_ref_if.sv ====
`timescale 1ns/1ns
// reference settings travel to the ladder decoder, level comes back
interface cvc_ref_if;
  import cvc_pkg::*;
  logic       range_low;
  cvc_tap_t   tap;
  cvc_level_t level;
  modport ctl    (output range_low, output tap, input level);
  modport ladder (input range_low, input tap, output level);
endinterface : cvc_ref_if

// ==== logic/cvc_sync.sv ====
`timescale 1ns/1ns
// three-stage synchroniser; output moves only when stages two and three agree
module cvc_sync (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage is read only by the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // agreement filter against a half-settled sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= 1'b0;
    end else if (s2_q == s3_q) begin
      q_o <= s3_q;
    end
  end
endmodule : cvc_sync

// ==== logic/cvc_ladder.sv ====
`timescale 1ns/1ns
`include "cvc_map.svh"
// digital image of the tap voltage, in 96ths of supply
module cvc_ladder
  import cvc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  cvc_ref_if.ladder ref_if
);
  cvc_level_t tap_w;
  cvc_level_t level_d;
  cvc_level_t level_q;

  assign tap_w = {3'h0, ref_if.tap};

  // low range tap/24, high range 1/4 + tap/32
  always_comb begin
    if (ref_if.range_low) begin
      level_d = 7'(tap_w * `CVC_LOW_STEP);
    end else begin
      level_d = 7'(`CVC_HIGH_BASE + tap_w * `CVC_HIGH_STEP);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_q <= `CVC_HIGH_BASE;
    end else begin
      level_q <= level_d;
    end
  end

  assign ref_if.level = level_q;
endmodule : cvc_ladder

// ==== testbench/cvc_top_properties.sv ====
`timescale 1ns/1ns
// ======================================
// port-level checks for the comparator and reference block
module cvc_top_checker
  import cvc_pkg::*;
(
  input logic       clk_i,
  input logic       rst_b_i,
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic       reg_wr_i,
  input logic       reg_rd_i,
  input cvc_byte_t  reg_rdata_o,
  input logic       cmp_first_raw_i,
  input logic       sleep_i,
  input logic [1:0] cmp_power_o,
  input cvc_mode_t  comparator_mode_field_o,
  input logic       cmp_use_ref_o,
  input logic       first_compare_result_o,
  input logic       second_compare_result_o,
  input logic       compare_change_flag_o,
  input logic       compare_change_enable_o,
  input logic       wake_o,
  input logic [4:0] porta_direction_o,
  input logic       porta_line_three_o,
  input logic       porta_line_three_oe_b_o,
  input logic       ref_power_on_o,
  input logic       ref_range_select_o,
  input cvc_tap_t   ref_tap_select_o,
  input cvc_level_t ref_level_o,
  input logic       ref_line_two_connect_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // write data of the previous edge, since $past takes no bit select
  logic [7:0] wd_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wd_q <= 8'h00;
    else wd_q <= reg_wdata_i;
  end

  // ======================================
  // register port and reference
  a_ref_bit4_zero: assert property (
    reg_rd_i && reg_addr_i == 8'h9f |=> !reg_rdata_o[4]) else $error("reference bit 4 reads one");
  a_ref_write_lands: assert property (
    reg_wr_i && reg_addr_i == 8'h9f |=>
    {ref_power_on_o, ref_range_select_o, ref_tap_select_o} == {wd_q[7], wd_q[5], wd_q[3:0]})
    else $error("reference write not applied");
  a_level_map: assert property (ref_level_o == ($past(ref_range_select_o) ?
    {1'b0, $past(ref_tap_select_o), 2'b00} : 7'h18 + 7'($past(ref_tap_select_o)) * 7'h03))
    else $error("reference level wrong for range and tap");
  a_pin_connect: assert property (
    reg_wr_i && reg_addr_i == 8'h9f |=> ref_line_two_connect_o == (wd_q[6] && porta_direction_o[2]))
    else $error("line two connection wrong");
  a_ref_indep: assert property (reg_wr_i && reg_addr_i == 8'h1f |=>
    $stable(ref_tap_select_o) && $stable(ref_range_select_o) && $stable(ref_power_on_o))
    else $error("comparator write disturbed reference");

  // ======================================
  // comparators, flag and wake
  // power is registered, so it follows the mode field one cycle later
  a_off_unpowered: assert property (
    comparator_mode_field_o inside {CVC_MODE_RESET, CVC_MODE_OFF} |=> cmp_power_o == 2'b00)
    else $error("comparator powered in off mode");
  a_ref_mode_route: assert property (
    cmp_use_ref_o == (comparator_mode_field_o == CVC_MODE_REF)) else $error("reference routing");
  a_change_flags: assert property (
    $changed(first_compare_result_o) || $changed(second_compare_result_o) |=> compare_change_flag_o)
    else $error("output change did not set flag");
  a_flag_holds: assert property (
    compare_change_flag_o && !(reg_wr_i && reg_addr_i == 8'h0c) |=> compare_change_flag_o)
    else $error("flag dropped without a clear");
  a_wake_sleep: assert property (
    sleep_i && compare_change_flag_o && compare_change_enable_o && !reg_wr_i |=> wake_o)
    else $error("no wake from sleep");
  a_sleep_exit: assert property ($fell(sleep_i) && !$past(reg_wr_i) |->
    $stable(comparator_mode_field_o) && $stable(ref_tap_select_o) && $stable(ref_power_on_o))
    else $error("registers changed on wake");
  a_pin_three: assert property (!porta_line_three_oe_b_o |->
    comparator_mode_field_o == CVC_MODE_PINOUT && !porta_direction_o[3] &&
    porta_line_three_o == cmp_first_raw_i) else $error("line three driven wrongly");

  c_wake: cover property (wake_o);
  c_pin_three: cover property (!porta_line_three_oe_b_o);
  c_line_two: cover property (ref_line_two_connect_o);
endmodule : cvc_top_checker

bind cvc_top cvc_top_checker u_chk (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .cmp_first_raw_i, .sleep_i, .cmp_power_o, .comparator_mode_field_o,
  .cmp_use_ref_o, .first_compare_result_o, .second_compare_result_o, .compare_change_flag_o,
  .compare_change_enable_o, .wake_o, .porta_direction_o, .porta_line_three_o,
  .porta_line_three_oe_b_o, .ref_power_on_o, .ref_range_select_o, .ref_tap_select_o,
  .ref_level_o, .ref_line_two_connect_o);

// ==== testbench/cvc_top_tb_top.sv ====
`timescale 1ns/1ns
module cvc_top_tb_top
  import cvc_pkg::*;
;
  logic       clk_i, rst_b_i, reg_wr_i, reg_rd_i, cmp_first_raw_i, cmp_second_raw_i, sleep_i;
  logic [7:0] reg_addr_i, reg_wdata_i, v;
  cvc_byte_t  reg_rdata_o;
  cvc_mode_t  comparator_mode_field_o;
  cvc_tap_t   ref_tap_select_o;
  cvc_level_t ref_level_o;
  logic [1:0] cmp_power_o;
  logic [4:0] porta_direction_o;
  logic       input_switch_bit_o, cmp_use_ref_o, pins_all_analog_o, first_compare_result_o,
              second_compare_result_o, compare_change_flag_o, compare_change_enable_o,
              cmp_irq_req_o, wake_o, porta_line_three_o, porta_line_three_oe_b_o,
              porta_line_four_o, porta_line_four_oe_b_o, ref_power_on_o, ref_range_select_o,
              ref_line_two_connect_o, rd_pend;
  int         err_count, samples_checked, cycles, i;
  cvc_byte_t  exp_q[$];
  logic [7:0] rst_addr[6] = '{8'h0c, 8'h1f, 8'h85, 8'h8c, 8'h9f, 8'h40};
  logic [7:0] rst_val[6]  = '{8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};
  logic [2:0] modes[5]    = '{3'b000, 3'b010, 3'b011, 3'b110, 3'b111};

  cvc_top uut (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .cmp_first_raw_i, .cmp_second_raw_i, .sleep_i, .cmp_power_o, .comparator_mode_field_o,
    .input_switch_bit_o, .cmp_use_ref_o, .pins_all_analog_o, .first_compare_result_o,
    .second_compare_result_o, .compare_change_flag_o, .compare_change_enable_o, .cmp_irq_req_o,
    .wake_o, .porta_direction_o, .porta_line_three_o, .porta_line_three_oe_b_o,
    .porta_line_four_o, .porta_line_four_oe_b_o, .ref_power_on_o, .ref_range_select_o,
    .ref_tap_select_o, .ref_level_o, .ref_line_two_connect_o);

  // ======================================
  // clock, hang guard, verdict
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // whole run is a few hundred cycles; generous ceiling
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ======================================
  // register port master
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
    // let the level follow its register before anyone looks
    repeat (2) @(negedge clk_i);
  endtask : wr

  // expected read data is noted; the monitor below compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
  endtask : rd

  // read data stands only in the cycle after the strobe
  always @(posedge clk_i) rd_pend <= reg_rd_i;
  always @(negedge clk_i) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0) check(reg_rdata_o, exp_q.pop_front());
  end

  // ======================================
  // main sequence
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, cmp_first_raw_i, cmp_second_raw_i, sleep_i, rd_pend} = '0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    void'($urandom(32'h4ec0f17a));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check(cmp_power_o, 8'h00);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (rst_addr[k]) rd(rst_addr[k], rst_val[k]);
    @(negedge clk_i);
    check(pins_all_analog_o, 8'h01);
    // every tap with random enable, pin and range bits
    for (i = 0; i < 16; i++) begin
      v = 8'($urandom);
      v[3:0] = i[3:0];
      wr(8'h9f, v);
      check(ref_level_o, v[5] ? {i[4:0], 2'b00} : 8'd24 + 8'(i * 3));
      check({ref_power_on_o, ref_line_two_connect_o}, v[7:6]);
      rd(8'h9f, v & 8'hef);
    end
    wr(8'h85, 8'h1b);
    wr(8'h9f, 8'hc0);
    check(ref_line_two_connect_o, 8'h00);
    rd(8'h85, 8'h1b);
    // modes, with the reference left alone
    foreach (modes[k]) begin
      wr(8'h1f, {5'h01, modes[k]});
      check(cmp_power_o == 2'b00, modes[k] inside {3'b000, 3'b111});
      check({cmp_use_ref_o, input_switch_bit_o}, {modes[k] == 3'b010, 1'b1});
      check({ref_power_on_o, ref_tap_select_o}, 8'h10);
      rd(8'h1f, {5'h01, modes[k]});
    end
    // raw outputs on lines three and four, gated by direction
    wr(8'h85, 8'h07);
    wr(8'h1f, 8'h06);
    @(posedge clk_i);
    cmp_first_raw_i <= 1'b1;
    @(negedge clk_i);
    check({porta_line_three_oe_b_o, porta_line_three_o, porta_line_four_oe_b_o,
           porta_line_four_o}, 8'h04);
    wr(8'h85, 8'h0f);
    check({porta_line_three_oe_b_o, porta_line_four_oe_b_o}, 8'h02);
    // the flag rises only after the synchroniser and one more edge
    repeat (3) @(posedge clk_i);
    // mismatch keeps setting the flag until the control register is touched
    rd(8'h0c, 8'h40);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h40);
    rd(8'h1f, 8'h46);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h00);
    // reference powered down before sleep; change during sleep wakes the core
    wr(8'h9f, 8'h46);
    wr(8'h8c, 8'h40);
    wr(8'h1f, 8'h02);
    @(posedge clk_i);
    sleep_i          <= 1'b1;
    cmp_second_raw_i <= 1'b1;
    for (i = 0; i < 20 && wake_o !== 1'b1; i++) @(negedge clk_i);
    check(wake_o, 8'h01);
    check({cmp_irq_req_o, compare_change_enable_o, first_compare_result_o,
           second_compare_result_o}, 8'h0f);
    check({porta_direction_o, comparator_mode_field_o}, 8'h7a);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    rd(8'h1f, 8'hc2);
    rd(8'h9f, 8'h46);
    // second reset in mid-run
    @(posedge clk_i);
    {cmp_first_raw_i, cmp_second_raw_i} <= 2'b00;
    rst_b_i <= 1'b0;
    @(negedge clk_i);
    check(cmp_power_o, 8'h00);
    check(wake_o, 8'h00);
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (rst_addr[k]) rd(rst_addr[k], rst_val[k]);
    repeat (3) @(posedge clk_i);
    wrap_up();
  end
endmodule : cvc_top_tb_top
